/* File: hdl/checksum_accum.sv */
// running byte sum over the checksummed part of a packet
`timescale 1ns/1ns
module checksum_accum (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       clear,
    input  wire logic       add_en,
    input  wire logic [7:0] add_byte,
    output logic      [6:0] sum
);
    typedef struct packed {
        logic [7:0] acc;
    } accum_state_t;

    accum_state_t q;
    accum_state_t d;

    always_comb begin
        d = q;
        if (clear) begin
            d.acc = 8'h00;
        end else if (add_en) begin
            d.acc = q.acc + add_byte;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sum = q.acc[6:0];
endmodule

/* File: hdl/framer_pkg.sv */
// constants and types shared by the sliced text packet framer
package framer_pkg;

    // ------------------------------------------------------------
    // register subaddresses and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HDR_ID_ADDR    = 8'h5d;
    localparam logic [7:0] SRC_ID_ADDR    = 8'h5e;
    localparam logic [5:0] HDR_ID_RESET   = 6'h00;
    localparam logic [5:0] SRC_ID_RESET   = 6'h00;

    // ------------------------------------------------------------
    // header selection and field layout
    // ------------------------------------------------------------
    localparam logic [5:0] ANC_PLAIN_ID   = 6'h00;
    localparam logic [5:0] TC_HIGH_ID     = 6'h3e;
    localparam logic [2:0] ANC_FIXED_BITS = 3'h2;
    localparam logic [8:0] EARLY_LAST_LN  = 9'h017;

    // ------------------------------------------------------------
    // counts and byte codes
    // ------------------------------------------------------------
    localparam logic [5:0] TC_WORD_COUNT  = 6'h0b;
    localparam logic [5:0] ID_BYTE_COUNT  = 6'h02;
    localparam logic [5:0] WORD_ROUND_UP  = 6'h03;
    localparam logic [5:0] MAX_DECODED    = 6'h2a;
    localparam logic [7:0] FILL_BYTE      = 8'ha0;
    localparam logic [7:0] IDLE_BYTE      = 8'h00;
    localparam logic [7:0] LEAD_ONES      = 8'hff;
    localparam logic [7:0] LEAD_ZERO      = 8'h00;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_LEAD0 = 4'h1,
        S_LEAD1 = 4'h2,
        S_LEAD2 = 4'h3,
        S_HEAD  = 4'h4,
        S_SRC   = 4'h5,
        S_COUNT = 4'h6,
        S_ID1   = 4'h7,
        S_ID2   = 4'h8,
        S_PAY   = 4'h9,
        S_CSUM  = 4'ha,
        S_BCNT  = 4'hb,
        S_ELEAD0 = 4'hc,
        S_ELEAD1 = 4'hd,
        S_ELEAD2 = 4'he,
        S_END_CODE = 4'hf
    } frame_state_t;

endpackage

/* File: hdl/header_parity.sv */
// parity encoder for protected header bytes and odd parity bytes
`timescale 1ns/1ns
module header_parity (
    input  wire logic [5:0] prot_bits,
    input  wire logic [6:0] odd_bits,
    output logic      [7:0] prot_byte,
    output logic      [7:0] odd_byte
);
    logic even_parity_bit;

    always_comb begin
        even_parity_bit = ^prot_bits;
        prot_byte       = {~even_parity_bit, even_parity_bit, prot_bits};
        odd_byte        = {~(^odd_bits), odd_bits};
    end
endmodule

/* File: hdl/sliced_vbi_packet_framer.sv */
// sliced text packet framer for the 8-bit image output port
`timescale 1ns/1ns
module sliced_vbi_packet_framer (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       line_start,
    input  wire logic       field_flag,
    input  wire logic [8:0] line_number,
    input  wire logic [3:0] data_type_code,
    input  wire logic [5:0] decoded_count,
    input  wire logic       vblank,
    input  wire logic       slice_valid,
    input  wire logic [7:0] slice_data,
    output logic            slice_ready,
    output logic      [7:0] out_data,
    output logic            out_valid,
    output logic            busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        framer_pkg::frame_state_t state;
        logic [5:0]               hdr_id;
        logic [5:0]               src_id;
        logic                     tc;
        logic                     field_flag;
        logic                     vflag;
        logic [8:0]               line_number;
        logic [3:0]               data_type_code;
        logic [5:0]               n;
        logic [5:0]               idx;
        logic [7:0]               out_data;
        logic                     out_valid;
        logic [7:0]               rdata;
    } framer_state_t;

    framer_state_t q;
    framer_state_t d;

    logic [5:0] prot_bits;
    logic [6:0] odd_bits;
    logic [7:0] prot_byte;
    logic [7:0] odd_byte;
    logic [6:0] cs_sum;
    logic       cs_clear;
    logic       cs_add;
    logic [5:0] word_count;
    logic [5:0] slots;
    logic [5:0] n_sat;
    logic [1:0] region;

    header_parity i_header_parity (
        .prot_bits (prot_bits),
        .odd_bits  (odd_bits),
        .prot_byte (prot_byte),
        .odd_byte  (odd_byte)
    );

    checksum_accum i_checksum_accum (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clear    (cs_clear),
        .add_en   (cs_add),
        .add_byte (d.out_data),
        .sum      (cs_sum)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] timing_code(input logic msb, input logic f, input logic v, input logic h);
        timing_code = {msb, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    always_comb begin
        // oversized requests are clipped so the count bytes never wrap
        n_sat = (decoded_count > framer_pkg::MAX_DECODED) ? framer_pkg::MAX_DECODED : decoded_count;
        if (q.tc) begin
            word_count = framer_pkg::TC_WORD_COUNT;
        end else begin
            word_count = (q.n + framer_pkg::ID_BYTE_COUNT + framer_pkg::WORD_ROUND_UP) >> 2;
        end
        slots = 6'({word_count, 2'b00} - 8'(framer_pkg::ID_BYTE_COUNT));
        if (q.line_number == 9'h000) begin
            region = 2'h0;
        end else if (q.line_number <= framer_pkg::EARLY_LAST_LN) begin
            region = 2'h1;
        end else begin
            region = 2'h3;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        d           = q;
        slice_ready = 1'b0;
        cs_clear    = 1'b0;
        cs_add      = 1'b0;
        prot_bits   = 6'h00;
        odd_bits    = 7'h00;
        d.out_valid = 1'b1;
        d.out_data  = framer_pkg::IDLE_BYTE;
        if (reg_write && reg_addr == framer_pkg::HDR_ID_ADDR) begin
            d.hdr_id = reg_wdata[5:0];
        end
        if (reg_write && reg_addr == framer_pkg::SRC_ID_ADDR) begin
            d.src_id = reg_wdata[5:0];
        end
        unique case (reg_addr)
            framer_pkg::HDR_ID_ADDR: d.rdata = {2'h0, q.hdr_id};
            framer_pkg::SRC_ID_ADDR: d.rdata = {2'h0, q.src_id};
            default:                 d.rdata = 8'h00;
        endcase
        unique case (q.state)
            framer_pkg::S_IDLE: begin
                d.out_valid = 1'b0;
                if (line_start) begin
                    d.tc    = (q.hdr_id >= framer_pkg::TC_HIGH_ID);
                    d.field_flag     = field_flag;
                    d.vflag          = vblank;
                    d.line_number    = line_number;
                    d.data_type_code = data_type_code;
                    d.n     = n_sat;
                    cs_clear = 1'b1;
                    d.state = framer_pkg::S_LEAD0;
                end
            end
            framer_pkg::S_LEAD0: begin
                d.out_data = q.tc ? framer_pkg::LEAD_ONES : framer_pkg::LEAD_ZERO;
                d.state    = framer_pkg::S_LEAD1;
            end
            framer_pkg::S_LEAD1: begin
                d.out_data = q.tc ? framer_pkg::LEAD_ZERO : framer_pkg::LEAD_ONES;
                d.state    = framer_pkg::S_LEAD2;
            end
            framer_pkg::S_LEAD2: begin
                d.out_data = q.tc ? framer_pkg::LEAD_ZERO : framer_pkg::LEAD_ONES;
                d.state    = framer_pkg::S_HEAD;
            end
            framer_pkg::S_HEAD: begin
                if (q.tc) begin
                    // 3eh sets the msb, 3fh clears it
                    d.out_data = timing_code(~q.hdr_id[0], q.field_flag, q.vflag, 1'b0);
                end else if (q.hdr_id == framer_pkg::ANC_PLAIN_ID) begin
                    prot_bits  = {framer_pkg::ANC_FIXED_BITS, q.field_flag, region};
                    d.out_data = prot_byte;
                end else begin
                    prot_bits  = {1'b0, q.hdr_id[4:0]};
                    d.out_data = prot_byte;
                end
                cs_add  = 1'b1;
                d.state = framer_pkg::S_SRC;
            end
            framer_pkg::S_SRC: begin
                prot_bits  = q.src_id;
                d.out_data = prot_byte;
                cs_add     = 1'b1;
                d.state    = framer_pkg::S_COUNT;
            end
            framer_pkg::S_COUNT: begin
                prot_bits  = word_count;
                d.out_data = prot_byte;
                cs_add     = 1'b1;
                d.state    = framer_pkg::S_ID1;
            end
            framer_pkg::S_ID1: begin
                odd_bits   = {q.field_flag, q.line_number[8:3]};
                d.out_data = odd_byte;
                cs_add     = 1'b1;
                d.state    = framer_pkg::S_ID2;
            end
            framer_pkg::S_ID2: begin
                odd_bits   = {q.line_number[2:0], q.data_type_code};
                d.out_data = odd_byte;
                cs_add     = 1'b1;
                d.idx      = 6'h00;
                d.state    = framer_pkg::S_PAY;
            end
            framer_pkg::S_PAY: begin
                if (q.idx < q.n) begin
                    // a stalled source costs a cycle marked invalid, not a gap in the count
                    if (slice_valid) begin
                        slice_ready = 1'b1;
                        d.out_data  = slice_data;
                        d.idx       = q.idx + 6'h01;
                        cs_add      = 1'b1;
                    end else begin
                        d.out_valid = 1'b0;
                    end
                end else begin
                    d.out_data = framer_pkg::FILL_BYTE;
                    d.idx      = q.idx + 6'h01;
                    cs_add     = 1'b1;
                end
                if (d.idx == slots && d.out_valid) begin
                    d.state = framer_pkg::S_CSUM;
                end
            end
            framer_pkg::S_CSUM: begin
                d.out_data = {cs_sum[6], cs_sum};
                d.state    = framer_pkg::S_BCNT;
            end
            framer_pkg::S_BCNT: begin
                odd_bits   = {1'b0, 6'(q.n + framer_pkg::ID_BYTE_COUNT)};
                d.out_data = odd_byte;
                d.state    = q.tc ? framer_pkg::S_ELEAD0 : framer_pkg::S_IDLE;
            end
            framer_pkg::S_ELEAD0: begin
                d.out_data = framer_pkg::LEAD_ONES;
                d.state    = framer_pkg::S_ELEAD1;
            end
            framer_pkg::S_ELEAD1: begin
                d.out_data = framer_pkg::LEAD_ZERO;
                d.state    = framer_pkg::S_ELEAD2;
            end
            framer_pkg::S_ELEAD2: begin
                d.out_data = framer_pkg::LEAD_ZERO;
                d.state    = framer_pkg::S_END_CODE;
            end
            framer_pkg::S_END_CODE: begin
                d.out_data = timing_code(~q.hdr_id[0], q.field_flag, q.vflag, 1'b1);
                d.state    = framer_pkg::S_IDLE;
            end
        endcase
        if (!d.out_valid) begin
            d.out_data = framer_pkg::IDLE_BYTE;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q        <= '0;
            q.state  <= framer_pkg::S_IDLE;
            q.hdr_id <= framer_pkg::HDR_ID_RESET;
            q.src_id <= framer_pkg::SRC_ID_RESET;
        end else begin
            q <= d;
        end
    end

    assign out_data  = q.out_data;
    assign out_valid = q.out_valid;
    assign reg_rdata = q.rdata;
    assign busy      = (q.state != framer_pkg::S_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence tc_lead_s;
        out_data == 8'hff ##1 out_data == 8'h00 ##1 out_data == 8'h00;
    endsequence

    sequence tc_tail_s;
        tc_lead_s ##1 out_data[4] == 1'b1;
    endsequence

    idle_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !out_valid |-> out_data == 8'h00) else $error("invalid cycle not coded 00h");

    tc_lead_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.state == framer_pkg::S_LEAD0 && q.tc) |=> tc_lead_s ##1 out_data[4] == 1'b0)
        else $error("start code lead-in wrong");

    tc_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.state == framer_pkg::S_BCNT && q.tc) |=> ##1 tc_tail_s) else $error("end code sequence wrong");

    tc_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.state == framer_pkg::S_COUNT && q.tc) |=> out_data == 8'h4b) else $error("fixed count byte not 4bh");

    src_byte_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        q.state == framer_pkg::S_SRC |=> out_data[5:0] == $past(q.src_id) && out_data[7] != out_data[6])
        else $error("source byte wrong");

    hdr_parity_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.state == framer_pkg::S_HEAD && !q.tc) |=> out_data[6] == ^out_data[5:0] && out_data[7] == !out_data[6])
        else $error("header parity wrong");

    id_one_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        q.state == framer_pkg::S_ID1 |=> out_data[6] == q.field_flag && out_data[5:0] == q.line_number[8:3]
        && ^out_data)
        else $error("first ident byte wrong");

    id_two_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        q.state == framer_pkg::S_ID2 |=> out_data[3:0] == q.data_type_code && out_data[6:4] == q.line_number[2:0]
        && ^out_data)
        else $error("second ident byte wrong");

    fill_byte_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (q.state == framer_pkg::S_PAY && q.idx >= q.n) |=> out_valid && out_data == 8'ha0)
        else $error("fill byte not a0h");

    valid_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        q.state == framer_pkg::S_BCNT |=> out_data[5:0] == 6'(q.n + 6'h02) && !out_data[6] && ^out_data)
        else $error("valid count byte wrong");

    csum_order_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        q.state == framer_pkg::S_CSUM |=> q.state == framer_pkg::S_BCNT && out_data[7] == out_data[6])
        else $error("checksum not followed by valid count");
endmodule

/* File: sim/test_sliced_vbi_packet_framer.sv */
// self-checking testbench for the sliced text packet framer
`timescale 1ns/1ns
module test_sliced_vbi_packet_framer;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       sys_clk;
    logic       resetn;
    logic       reg_write;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       line_start;
    logic       field_flag;
    logic [8:0] line_number;
    logic [3:0] data_type_code;
    logic [5:0] decoded_count;
    logic       vblank;
    logic       slice_valid;
    logic [7:0] slice_data;
    logic       slice_ready;
    logic [7:0] out_data;
    logic       out_valid;
    logic       busy;
    logic       clear;
    logic       stall_en;
    logic [7:0] cur_byte;
    logic [7:0] n_cap;
    logic [7:0] idle_bad;
    int         n_fail;
    int         comparisons;
    int         cycles;
    logic [7:0] exp_b [0:127];
    int         n_exp;

    sliced_vbi_packet_framer i_sliced_vbi_packet_framer (
        .sys_clk(sys_clk), .resetn(resetn), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_start(line_start), .field_flag(field_flag),
        .line_number(line_number), .data_type_code(data_type_code), .decoded_count(decoded_count),
        .vblank(vblank), .slice_valid(slice_valid), .slice_data(slice_data), .slice_ready(slice_ready),
        .out_data(out_data), .out_valid(out_valid), .busy(busy));
    vbi_capture_model u_cap (
        .sys_clk(sys_clk), .resetn(resetn), .clear(clear), .stall_en(stall_en), .slice_ready(slice_ready),
        .out_data(out_data), .out_valid(out_valid), .slice_valid(slice_valid), .slice_data(slice_data),
        .cur_byte(cur_byte), .n_cap(n_cap), .idle_bad(idle_bad));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] prot(input logic [5:0] b);
        prot = {~(^b), ^b, b};
    endfunction
    function automatic logic [7:0] odd(input logic [6:0] b);
        odd = {~(^b), b};
    endfunction
    task automatic push(input logic [7:0] b);
        exp_b[n_exp] = b;
        n_exp++;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_write = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        @(negedge sys_clk);
        cmp8(reg_rdata, exp);
    endtask
    // expected packet, payload taken as base, base+1, ... from the source model
    task automatic build_exp(input logic [5:0] id, input logic [5:0] src, input logic f, input logic [8:0] lno,
                             input logic [3:0] dty, input logic [5:0] n, input logic vb, input logic [7:0] base);
        logic       ts;
        logic [5:0] wc;
        logic [7:0] s;
        logic [7:0] b;
        logic [1:0] rg;
        int         k;
        ts    = (id >= 6'h3e);
        wc    = ts ? 6'h0b : ((n + 6'h05) >> 2);
        rg    = (lno == 9'h000) ? 2'h0 : ((lno <= 9'h017) ? 2'h1 : 2'h3);
        n_exp = 0;
        if (ts) b = {id == 6'h3e, f, vb, 1'b0, vb, f, f ^ vb, f ^ vb};
        else if (id == 6'h00) b = prot({3'h2, f, rg});
        else b = prot({1'b0, id[4:0]});
        if (ts) push(8'hff);
        else push(8'h00);
        push(ts ? 8'h00 : 8'hff);
        push(ts ? 8'h00 : 8'hff);
        push(b);
        push(prot(src));
        push(prot(wc));
        push(odd({f, lno[8:3]}));
        push(odd({lno[2:0], dty}));
        s = b + prot(src) + prot(wc) + odd({f, lno[8:3]}) + odd({lno[2:0], dty});
        for (k = 0; k < 4 * wc - 2; k++) begin
            b = (k < n) ? base + k[7:0] : 8'ha0;
            s = s + b;
            push(b);
        end
        push({s[6], s[6:0]});
        push(odd({1'b0, n + 6'h02}));
        if (ts) begin
            push(8'hff);
            push(8'h00);
            push(8'h00);
            push({id == 6'h3e, f, vb, 1'b1, ~vb, ~f, f ^ vb, ~(f ^ vb)});
        end
    endtask
    task automatic run_packet(input logic [5:0] id, input logic [5:0] src, input logic f, input logic [8:0] lno,
                              input logic [3:0] dty, input logic [5:0] n, input logic vb, input logic st,
                              input logic dbl);
        logic [7:0] base;
        logic [5:0] nc;
        int         k;
        nc = (n > 6'h2a) ? 6'h2a : n;
        reg_wr(8'h5d, {2'h0, id});
        reg_wr(8'h5e, {2'h0, src});
        @(negedge sys_clk);
        clear          = 1'b1;
        stall_en       = st;
        field_flag     = f;
        line_number    = lno;
        data_type_code = dty;
        decoded_count  = n;
        vblank         = vb;
        base           = cur_byte;
        @(negedge sys_clk);
        clear      = 1'b0;
        line_start = 1'b1;
        @(negedge sys_clk);
        line_start = 1'b0;
        if (dbl) begin
            repeat (5) @(negedge sys_clk);
            line_start = 1'b1;
            @(negedge sys_clk);
            line_start = 1'b0;
        end
        k = 0;
        while (busy !== 1'b0 && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        repeat (3) @(negedge sys_clk);
        cmp8({7'h00, busy}, 8'h00);
        build_exp(id, src, f, lno, dty, nc, vb, base);
        cmp8(n_cap, n_exp[7:0]);
        for (k = 0; k < n_exp; k++) begin
            cmp8(u_cap.cap[k], exp_b[k]);
        end
        cmp8(cur_byte - base, {2'h0, nc});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        reg_rd(8'h5d, 8'h00);
        reg_rd(8'h5e, 8'h00);
        reg_wr(8'h5e, 8'hff);
        reg_rd(8'h5e, 8'h3f);
        reg_wr(8'h5d, 8'h3e);
        reg_rd(8'h5d, 8'h3e);
        reg_wr(8'h47, 8'h15);
        reg_rd(8'h47, 8'h00);
        reg_rd(8'h5d, 8'h3e);
    endtask
    task automatic test_timing_short();
        run_packet(6'h3e, 6'h15, 1'b0, 9'h12b, 4'h5, 6'h01, 1'b1, 1'b0, 1'b0);
    endtask
    // full payload, source stalls, and a start request while busy
    task automatic test_timing_full();
        run_packet(6'h3f, 6'h2a, 1'b1, 9'h0d6, 4'ha, 6'h2a, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic test_anc_regions();
        run_packet(6'h00, 6'h01, 1'b1, 9'h000, 4'h1, 6'h00, 1'b0, 1'b0, 1'b0);
        run_packet(6'h00, 6'h3c, 1'b0, 9'h001, 4'h2, 6'h01, 1'b0, 1'b0, 1'b0);
        run_packet(6'h00, 6'h07, 1'b1, 9'h017, 4'hc, 6'h06, 1'b0, 1'b1, 1'b0);
        run_packet(6'h00, 6'h30, 1'b0, 9'h018, 4'hf, 6'h32, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic test_anc_custom();
        run_packet(6'h3d, 6'h22, 1'b0, 9'h1f5, 4'h3, 6'h03, 1'b1, 1'b0, 1'b0);
        cmp8(idle_bad, 8'h00);
    endtask

    initial begin
        resetn         = 1'b0;
        reg_write      = 1'b0;
        reg_addr       = 8'h00;
        reg_wdata      = 8'h00;
        line_start     = 1'b0;
        field_flag     = 1'b0;
        line_number    = 9'h000;
        data_type_code = 4'h0;
        decoded_count  = 6'h00;
        vblank         = 1'b0;
        clear          = 1'b0;
        stall_en       = 1'b0;
        n_fail         = 0;
        comparisons    = 0;
        cycles         = 0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        test_regs();
        test_timing_short();
        test_timing_full();
        test_anc_regions();
        test_anc_custom();
        give_verdict();
    end
endmodule

/* File: sim/vbi_capture_model.sv */
// far-side model: slice byte source and image port capture
`timescale 1ns/1ns
module vbi_capture_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       clear,
    input  wire logic       stall_en,
    input  wire logic       slice_ready,
    input  wire logic [7:0] out_data,
    input  wire logic       out_valid,
    output logic            slice_valid,
    output logic      [7:0] slice_data,
    output logic      [7:0] cur_byte,
    output logic      [7:0] n_cap,
    output logic      [7:0] idle_bad
);
    // ------------------------------------------------------------
    // source and capture
    // ------------------------------------------------------------
    logic [7:0] cap [0:127];
    logic [7:0] data_q;
    logic       valid_q;
    assign slice_valid = valid_q;
    // no stale byte shown while nothing is offered
    assign slice_data  = valid_q ? data_q : ~data_q;
    assign cur_byte    = data_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_q   <= 8'h10;
            valid_q  <= 1'b0;
            n_cap    <= 8'h00;
            idle_bad <= 8'h00;
        end else begin
            if (valid_q && slice_ready) begin
                data_q  <= data_q + 8'h01;
                valid_q <= ~stall_en;
            end else begin
                valid_q <= 1'b1;
            end
            if (clear) begin
                n_cap <= 8'h00;
            end else if (out_valid) begin
                cap[n_cap[6:0]] <= out_data;
                n_cap           <= n_cap + 8'h01;
            end
            if (!out_valid && out_data !== 8'h00) begin
                idle_bad <= idle_bad + 8'h01;
            end
        end
    end
endmodule
